// ---- design/sei_pkg.sv ----
// Constants shared by the socket event request block
package sei_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned FLAG_W = 10;
   // Register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_XFER_SIZE = 12'h004;
   localparam logic [11:0] OFF_XFER_COUNT = 12'h008;
   localparam logic [11:0] OFF_STATUS = 12'h00c;
   localparam logic [11:0] OFF_REQUEST = 12'h010;
   localparam logic [11:0] OFF_MASK = 12'h014;
   localparam logic [11:0] OFF_REQ_SET = 12'h018;
   // Control register fields
   localparam int unsigned CTRL_ENABLE = 0;
   localparam int unsigned CTRL_GO_SUSPEND = 1;
   localparam int unsigned CTRL_SUSP_FINAL = 2;
   localparam int unsigned CTRL_SUSP_INCOMPLETE = 3;
   localparam int unsigned CTRL_SUSP_XFER = 4;
   localparam int unsigned CTRL_EGRESS = 5;
   localparam int unsigned CTRL_W = 6;
   // Request flag positions
   localparam int unsigned F_PRODUCE = 0;
   localparam int unsigned F_CONSUME = 1;
   localparam int unsigned F_DSCR_LOW = 2;
   localparam int unsigned F_NO_DSCR = 3;
   localparam int unsigned F_STALL = 4;
   localparam int unsigned F_SUSPEND = 5;
   localparam int unsigned F_ERROR = 6;
   localparam int unsigned F_XFER_DONE = 7;
   localparam int unsigned F_INCOMPLETE = 8;
   localparam int unsigned F_FINAL = 9;
   // Reset values and special codes
   localparam logic [9:0] FLAGS_RST = 10'h000;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [15:0] DSCR_NONE = 16'hffff;
endpackage

// ---- design/sei_socket_request.sv ----
// Socket event request register with mask, suspend tracking and APB access
//
// What this block does
// (RQ1) Flags latch regardless of mask settings
// (RQ2) Socket disable clears every pending flag
// (RQ3) Final-buffer suspend sets bit 9
// (RQ4) Egress incomplete-buffer suspend sets bit 8
// (RQ5) Resume only when bits 9:5 and forced-suspend clear
// (RQ6) Transfer size reached sets bit 7 if enabled
// (RQ7) Transfer counter advances by whole buffers only
// (RQ8) Ingress end of packet: counter unchanged unless suspending
// (RQ9) Error also suspends and sets suspend flag
// (RQ10) Four listed error causes raise error flag
// (RQ11) Suspend flag set on any cause, sticky
// (RQ12) Stall flag bit 4 sticky until cleared
// (RQ13) Descriptor number all ones sets bit 3
// (RQ14) Count dropping below watermark sets bit 2, sticky
// (RQ15) Consume event sets bit 1
// (RQ16) Produce event sets bit 0
// (RQ17) Interrupt forwards flag only when mask bit set
// (RQ18) Write one clears or sets; zero ignored
// (RQ19) Upper bits read zero, flags reset zero
`timescale 1ns/100ps
module sei_socket_request
   import sei_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [15:0] DSCR_NUMBER,
   input wire logic [7:0] DSCR_COUNT,
   input wire logic [7:0] DSCR_LOW_MARK,
   input wire logic BUF_DONE,
   input wire logic BUF_EOP,
   input wire logic [31:0] BUF_BYTES,
   input wire logic FINAL_BUF_HIT,
   input wire logic INCOMPLETE_BUF_HIT,
   input wire logic ERR_BUF_FLAGGED,
   input wire logic ERR_OVERSIZE,
   input wire logic ERR_WRITE_INACTIVE,
   input wire logic ERR_UNCONSUMED,
   input wire logic STALL_WAIT,
   input wire logic CONSUME_EVENT,
   input wire logic PRODUCE_EVENT,
   output logic IRQ,
   output logic SUSPENDED
);

   logic [CTRL_W-1:0] ctrl_q;
   logic [31:0] xfer_size_q;
   logic [31:0] xfer_count_q;
   logic [FLAG_W-1:0] flags_q;
   logic [FLAG_W-1:0] flags_d;
   logic [FLAG_W-1:0] mask_q;
   logic [FLAG_W-1:0] hw_set;
   logic [FLAG_W-1:0] sw_set;
   logic [FLAG_W-1:0] sw_clr;
   logic [7:0] dscr_count_q;
   logic susp_q;
   logic irq_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] count_sum;
   logic size_reached;
   logic bus_write;
   logic any_error;
   logic suspend_cause;
   logic enabled;
   logic egress;

   typedef enum logic [2:0] {
      SEL_CTRL, SEL_SIZE, SEL_COUNT, SEL_STATUS, SEL_REQUEST, SEL_MASK, SEL_SET, SEL_NONE
   } sei_sel_t;

   function automatic sei_sel_t decode(input logic [ADDR_W-1:0] addr);
      sei_sel_t sel;
      sel = SEL_NONE;
      if (addr == OFF_CTRL) begin
         sel = SEL_CTRL;
      end else if (addr == OFF_XFER_SIZE) begin
         sel = SEL_SIZE;
      end else if (addr == OFF_XFER_COUNT) begin
         sel = SEL_COUNT;
      end else if (addr == OFF_STATUS) begin
         sel = SEL_STATUS;
      end else if (addr == OFF_REQUEST) begin
         sel = SEL_REQUEST;
      end else if (addr == OFF_MASK) begin
         sel = SEL_MASK;
      end else if (addr == OFF_REQ_SET) begin
         sel = SEL_SET;
      end
      return sel;
   endfunction

   assign enabled = ctrl_q[CTRL_ENABLE];
   assign egress = ctrl_q[CTRL_EGRESS];
   // Write commits only on the completing access cycle
   assign bus_write = PSEL && PENABLE && pready_q && PWRITE;
   assign count_sum = xfer_count_q + BUF_BYTES;
   assign size_reached = count_sum >= xfer_size_q;

   assign any_error = ERR_BUF_FLAGGED | ERR_OVERSIZE | ERR_WRITE_INACTIVE
                      | ERR_UNCONSUMED; // RQ10

   always_comb begin
      hw_set = FLAGS_RST;
      hw_set[F_FINAL] = FINAL_BUF_HIT && ctrl_q[CTRL_SUSP_FINAL]; // RQ3
      hw_set[F_INCOMPLETE] = INCOMPLETE_BUF_HIT && egress
                             && ctrl_q[CTRL_SUSP_INCOMPLETE]; // RQ4
      hw_set[F_XFER_DONE] = BUF_DONE && size_reached && ctrl_q[CTRL_SUSP_XFER]; // RQ6
      hw_set[F_ERROR] = any_error; // RQ10
      hw_set[F_STALL] = STALL_WAIT; // RQ12
      hw_set[F_NO_DSCR] = DSCR_NUMBER == DSCR_NONE; // RQ13
      // Edge only, so a wrap back to a high count leaves the flag alone
      hw_set[F_DSCR_LOW] = (DSCR_COUNT < DSCR_LOW_MARK)
                           && !(dscr_count_q < DSCR_LOW_MARK); // RQ14
      hw_set[F_CONSUME] = CONSUME_EVENT; // RQ15
      hw_set[F_PRODUCE] = PRODUCE_EVENT; // RQ16
      // Any hardware cause or forced suspend marks the socket suspended
      hw_set[F_SUSPEND] = |hw_set[F_FINAL:F_ERROR] | hw_set[F_NO_DSCR]
                          | ctrl_q[CTRL_GO_SUSPEND]; // RQ9 RQ11
   end

   always_comb begin
      sw_set = FLAGS_RST;
      sw_clr = FLAGS_RST;
      if (bus_write && decode(PADDR) == SEL_REQUEST) begin
         sw_clr = PWDATA[FLAG_W-1:0]; // RQ18
      end
      if (bus_write && decode(PADDR) == SEL_SET) begin
         sw_set = PWDATA[FLAG_W-1:0]; // RQ18
      end
   end

   // Hardware set beats a simultaneous software clear; disable beats both
   always_comb begin
      if (!enabled) begin
         flags_d = FLAGS_RST; // RQ2
      end else begin
         flags_d = (flags_q & ~sw_clr) | hw_set | sw_set; // RQ1
      end
   end

   assign suspend_cause = (|flags_d[F_FINAL:F_SUSPEND]) || ctrl_q[CTRL_GO_SUSPEND];

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         flags_q <= FLAGS_RST; // RQ19
      end else begin
         flags_q <= flags_d;
      end
   end

   // Reset value counts as below the mark, so no drop is seen right after reset
   localparam logic [7:0] DSCR_COUNT_RST = 8'h00;
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         dscr_count_q <= DSCR_COUNT_RST;
      end else begin
         dscr_count_q <= DSCR_COUNT;
      end
   end

   // Suspend holds while any cause flag or forced suspend remains
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         susp_q <= 1'b0;
      end else if (!enabled) begin
         susp_q <= 1'b0;
      end else begin
         susp_q <= suspend_cause; // RQ5 RQ9
      end
   end

   // Counter grows per finished buffer; overshoot is left to software
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         xfer_count_q <= WORD_ZERO;
      end else if (!enabled) begin
         xfer_count_q <= WORD_ZERO;
      end else if (BUF_DONE) begin
         if (egress || !BUF_EOP || (size_reached && ctrl_q[CTRL_SUSP_XFER])) begin
            xfer_count_q <= count_sum; // RQ7 RQ8
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         ctrl_q <= CTRL_RST;
         xfer_size_q <= WORD_ZERO;
         mask_q <= FLAGS_RST;
      end else if (bus_write) begin
         if (decode(PADDR) == SEL_CTRL) begin
            ctrl_q <= PWDATA[CTRL_W-1:0];
         end else if (decode(PADDR) == SEL_SIZE) begin
            xfer_size_q <= PWDATA;
         end else if (decode(PADDR) == SEL_MASK) begin
            mask_q <= PWDATA[FLAG_W-1:0];
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags_q & mask_q); // RQ17
      end
   end

   // One wait state: data and PREADY registered on the same edge
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= WORD_ZERO;
      end else if (PSEL && PENABLE && !pready_q) begin
         pready_q <= 1'b1;
         pslverr_q <= decode(PADDR) == SEL_NONE;
         prdata_q <= WORD_ZERO;
         if (!PWRITE) begin
            case (decode(PADDR))
               SEL_CTRL: prdata_q[CTRL_W-1:0] <= ctrl_q;
               SEL_SIZE: prdata_q <= xfer_size_q;
               SEL_COUNT: prdata_q <= xfer_count_q;
               SEL_STATUS: prdata_q[0] <= susp_q;
               SEL_REQUEST: prdata_q[FLAG_W-1:0] <= flags_q; // RQ19
               SEL_MASK: prdata_q[FLAG_W-1:0] <= mask_q;
               default: prdata_q <= WORD_ZERO;
            endcase
         end
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign IRQ = irq_q;
   assign SUSPENDED = susp_q;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   a_mask_gates_irq: assert property ( // RQ17
      ##1 (IRQ == $past(|(flags_q & mask_q))))
      else $error("irq does not follow masked flags");

   a_flags_ignore_mask: assert property ( // RQ1
      (enabled && PRODUCE_EVENT && mask_q == FLAGS_RST) |=> flags_q[F_PRODUCE])
      else $error("produce flag lost while masked");

   a_disable_clears: assert property ( // RQ2
      !enabled |=> (flags_q == FLAGS_RST))
      else $error("flags survive socket disable");

   a_final_sets: assert property ( // RQ3
      (enabled && FINAL_BUF_HIT && ctrl_q[CTRL_SUSP_FINAL])
      |=> (flags_q[F_FINAL] && flags_q[F_SUSPEND]) ##1 susp_q)
      else $error("final buffer suspend not flagged");

   a_incomplete_ingress: assert property ( // RQ4
      (enabled && !egress && !flags_q[F_INCOMPLETE] && !sw_set[F_INCOMPLETE])
      |=> !flags_q[F_INCOMPLETE])
      else $error("incomplete flag set on ingress");

   a_resume_hold: assert property ( // RQ5
      (enabled && ((|flags_q[F_FINAL:F_SUSPEND])
                   || ($past(enabled) && $past(ctrl_q[CTRL_GO_SUSPEND])))) |-> susp_q)
      else $error("socket resumed with a cause pending");

   a_xfer_done: assert property ( // RQ6
      (enabled && BUF_DONE && size_reached && ctrl_q[CTRL_SUSP_XFER])
      |=> flags_q[F_XFER_DONE])
      else $error("transfer done not flagged");

   a_eop_count_hold: assert property ( // RQ8
      (enabled && BUF_DONE && BUF_EOP && !egress && !(size_reached && ctrl_q[CTRL_SUSP_XFER]))
      |=> $stable(xfer_count_q))
      else $error("counter moved on ingress end of packet");

   a_error_suspends: assert property ( // RQ9
      (enabled && ERR_OVERSIZE) |=> (flags_q[F_ERROR] && flags_q[F_SUSPEND]))
      else $error("error did not set suspend");

   a_no_dscr: assert property ( // RQ13
      (enabled && DSCR_NUMBER == DSCR_NONE) |=> flags_q[F_NO_DSCR])
      else $error("missing descriptor not flagged");

   a_set_wins: assert property ( // RQ18
      (enabled && CONSUME_EVENT && sw_clr[F_CONSUME]) |=> flags_q[F_CONSUME])
      else $error("clear beat a concurrent event");

   a_upper_zero: assert property ( // RQ19
      PREADY |-> (PRDATA[31:FLAG_W] == '0 || decode(PADDR) == SEL_SIZE
                  || decode(PADDR) == SEL_COUNT))
      else $error("reserved bits read nonzero");

   // Sticky flags: each cause shows one edge later and outlives its cause
   a_stall_flag: assert property ( // RQ12
      (enabled && STALL_WAIT) |=> flags_q[F_STALL])
      else $error("stall wait not flagged");

   a_low_edge: assert property ( // RQ14
      (enabled && (DSCR_COUNT < DSCR_LOW_MARK) && ($past(DSCR_COUNT) >= DSCR_LOW_MARK))
      |=> flags_q[F_DSCR_LOW])
      else $error("descriptor count drop not flagged");

   a_consume_flag: assert property ( // RQ15
      (enabled && CONSUME_EVENT) |=> flags_q[F_CONSUME])
      else $error("consume event not flagged");

   a_produce_flag: assert property ( // RQ16
      (enabled && PRODUCE_EVENT) |=> flags_q[F_PRODUCE])
      else $error("produce event not flagged");

   a_error_causes: assert property ( // RQ10
      (enabled && (ERR_BUF_FLAGGED || ERR_WRITE_INACTIVE || ERR_UNCONSUMED))
      |=> flags_q[F_ERROR])
      else $error("error cause not flagged");

   a_suspend_sticky: assert property ( // RQ11
      (enabled && flags_q[F_SUSPEND] && !sw_clr[F_SUSPEND]) |=> flags_q[F_SUSPEND])
      else $error("suspend flag dropped without a clear");

   a_count_hold: assert property ( // RQ7
      (enabled && !BUF_DONE) |=> $stable(xfer_count_q))
      else $error("counter moved without a finished buffer");

endmodule

// ---- sim/sei_core_model.sv ----
// Far-side core model: one-cycle event pulses into the socket
`timescale 1ns/100ps
module sei_core_model (
   input wire logic clk,
   output logic [10:0] ev,
   output logic [31:0] nbytes
);
   initial begin
      ev = 11'h000;
      nbytes = 32'h0000_0000;
   end
   // Byte count is not held after the pulse, so a late sample shows a wrong value
   task automatic pulse(input logic [10:0] v, input logic [31:0] n);
      @(posedge clk);
      ev <= v;
      nbytes <= n;
      @(posedge clk);
      ev <= 11'h000;
      nbytes <= ~n;
   endtask
endmodule

// ---- sim/tb_sei_socket_request.sv ----
// Self-checking bench for the socket event request block
`timescale 1ns/100ps
module tb_sei_socket_request;
   import sei_pkg::*;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd_q, nbytes;
   logic pready, pslverr, err_q, irq, suspended;
   logic [15:0] dscr_num = 16'h0000;
   logic [7:0] dscr_cnt = 8'h08;
   logic [7:0] low_mark = 8'h02;
   logic [10:0] ev;
   int bad_count = 0;
   int comparisons = 0;
   logic [9:0] ev_exp [9] = '{10'h220, 10'h120, 10'h060, 10'h060, 10'h060, 10'h060,
      10'h010, 10'h002, 10'h001};
   always #12.5 ref_clk = ~ref_clk;
   sei_core_model core (.clk(ref_clk), .ev(ev), .nbytes(nbytes));
   sei_socket_request dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .DSCR_NUMBER(dscr_num), .DSCR_COUNT(dscr_cnt),
      .DSCR_LOW_MARK(low_mark), .BUF_DONE(ev[0]), .BUF_EOP(ev[10]), .BUF_BYTES(nbytes),
      .FINAL_BUF_HIT(ev[1]), .INCOMPLETE_BUF_HIT(ev[2]), .ERR_BUF_FLAGGED(ev[3]),
      .ERR_OVERSIZE(ev[4]), .ERR_WRITE_INACTIVE(ev[5]), .ERR_UNCONSUMED(ev[6]),
      .STALL_WAIT(ev[7]), .CONSUME_EVENT(ev[8]), .PRODUCE_EVENT(ev[9]), .IRQ(irq),
      .SUSPENDED(suspended));
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(n, e, rd_q & m);
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      bad_count++;
      end_of_test;
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rdc("flags_rst", OFF_REQUEST, ALL, 32'h0);
      rdc("mask_rst", OFF_MASK, ALL, 32'h0);
      apb(1'b1, OFF_CTRL, 32'h0000_003d);
      for (int i = 0; i < 9; i++) begin
         core.pulse(11'(1 << (i + 1)), 32'h0);
         rdc("ev_flags", OFF_REQUEST, ALL, 32'(ev_exp[i]));
         chk("suspended", 32'(ev_exp[i][F_SUSPEND]), 32'(suspended));
         chk("irq_masked", 32'h0, 32'(irq));
         apb(1'b1, OFF_REQUEST, 32'h0000_03ff);
         rdc("cleared", OFF_REQUEST, ALL, 32'h0);
         chk("resumed", 32'h0, 32'(suspended));
      end
      apb(1'b1, OFF_XFER_SIZE, 32'h0000_0010);
      core.pulse(11'h001, 32'h0000_000c);
      rdc("count_a", OFF_XFER_COUNT, ALL, 32'h0000_000c);
      rdc("not_done", OFF_REQUEST, ALL, 32'h0);
      core.pulse(11'h001, 32'h0000_000c);
      rdc("count_b", OFF_XFER_COUNT, ALL, 32'h0000_0018);
      rdc("xfer_done", OFF_REQUEST, 32'h0000_00a0, 32'h0000_00a0);
      apb(1'b1, OFF_REQUEST, 32'h0000_03ff);
      // Consume event lands on the very edge that commits the clear: the event wins
      fork
         begin
            repeat (2) @(posedge ref_clk);
            core.pulse(11'h100, 32'h0);
         end
         apb(1'b1, OFF_REQUEST, 32'h0000_0002);
      join
      rdc("set_wins", OFF_REQUEST, 32'h0000_0002, 32'h0000_0002);
      // Ingress with only incomplete-buffer suspend enabled
      apb(1'b1, OFF_CTRL, 32'h0000_0009);
      core.pulse(11'h401, 32'h0000_000c);
      rdc("eop_count", OFF_XFER_COUNT, ALL, 32'h0000_0018);
      core.pulse(11'h001, 32'h0000_0004);
      rdc("count_c", OFF_XFER_COUNT, ALL, 32'h0000_001c);
      core.pulse(11'h004, 32'h0);
      rdc("no_done_off", OFF_REQUEST, 32'h0000_0180, 32'h0);
      dscr_num <= DSCR_NONE;
      @(posedge ref_clk);
      dscr_num <= 16'h0000;
      dscr_cnt <= 8'h01;
      @(posedge ref_clk);
      dscr_cnt <= 8'hff;
      rdc("dscr_flags", OFF_REQUEST, 32'h0000_000c, 32'h0000_000c);
      apb(1'b1, OFF_REQUEST, 32'h0000_03ff);
      apb(1'b1, OFF_REQ_SET, 32'hffff_fc01);
      apb(1'b1, OFF_REQUEST, 32'h0);
      rdc("w1s", OFF_REQUEST, ALL, 32'h1);
      apb(1'b1, OFF_MASK, 32'h1);
      rdc("mask_rw", OFF_MASK, ALL, 32'h1);
      chk("irq_on", 32'h1, 32'(irq));
      apb(1'b1, OFF_MASK, 32'h2);
      rdc("mask_rw2", OFF_MASK, ALL, 32'h2);
      chk("irq_off", 32'h0, 32'(irq));
      apb(1'b1, OFF_CTRL, 32'h3);
      apb(1'b1, OFF_REQUEST, 32'h0000_0020);
      rdc("forced", OFF_REQUEST, 32'h0000_0020, 32'h0000_0020);
      chk("held", 32'h1, 32'(suspended));
      apb(1'b1, OFF_CTRL, 32'h1);
      apb(1'b1, OFF_REQUEST, 32'h0000_03ff);
      rdc("status", OFF_STATUS, 32'h1, 32'h0);
      apb(1'b1, OFF_REQ_SET, 32'h0000_03ff);
      apb(1'b1, OFF_CTRL, 32'h0);
      rdc("disable_clr", OFF_REQUEST, ALL, 32'h0);
      apb(1'b0, 12'hffc, 32'h0);
      chk("slverr", 32'h1, 32'(err_q));
      chk("unmapped", 32'h0, rd_q);
      end_of_test;
   end
endmodule
